/* File: hdl/pcb_power_regs.sv */
// Power control and backup register bank behind the serial control port.
// Assumes the serial port engine outside delivers decoded word accesses.
// How it works
// - Cut timer, tally, limit; cleared on power-on
// - Bit 0 enables restart after system reset
// - Bits 1-3 let buttons cause reset
// - Two-bit debounce select per button
// - Bit 10 makes primary request active low
// - Bit 11 makes secondary request active low
// - Bit 12 watchdog reset; cleared by system reset
// - Bits 17-18 select slow clock drive strength
// - Bits 22-23 delay; system reset gives one
// - Tally advances only while its enable set
`timescale 1ns/10ps
`include "pcb_regs.svh"

module pcb_power_regs #(
  parameter int unsigned DBNC_CYC0 = `PCB_DBNC0_CYC,  // Debounce code 0
  parameter int unsigned DBNC_CYC1 = `PCB_DBNC1_CYC,  // Debounce code 1
  parameter int unsigned DBNC_CYC2 = `PCB_DBNC2_CYC,  // Debounce code 2
  parameter int unsigned DBNC_CYC3 = `PCB_DBNC3_CYC   // Debounce code 3
) (
  input  wire logic        clk_sys_in,                   // System clock
  input  wire logic        resetn_in,                    // Power-on reset
  input  wire logic        system_reset_n_in,            // System reset pin
  input  pcb_pkg::pcb_req_s reg_req_in,                  // Register access
  output logic [23:0]      reg_rdata_out,                // Read data
  output logic             reg_rvalid_out,               // Read answer
  input  wire logic        cut_tally_enable_in,          // Tally enable
  input  wire logic        cut_event_in,                 // One cut seen
  input  wire logic [2:0]  power_button_in,              // Button pins
  input  wire logic        watchdog_input_in,            // Watchdog pin
  input  wire logic        primary_lowpower_request_in,  // Primary pin
  input  wire logic        secondary_lowpower_request_in,// Secondary pin
  output pcb_pkg::pcb_cut_s cut_settings_out,            // Cut settings
  output pcb_pkg::pcb_btn_s btn_settings_out,            // Misc settings
  output logic [2:0]       button_reset_req_out,         // Button resets
  output logic             watchdog_reset_req_out,       // Watchdog reset
  output logic             primary_lowpower_req_out,     // Primary, high
  output logic             secondary_lowpower_req_out    // Secondary, high
);

  pcb_pkg::pcb_state_s s_q;   // Whole bank state
  pcb_pkg::pcb_state_s s_d;   // Next bank state
  logic [2:0]          deb;   // Debounced buttons
  logic                wr_cut; // Write to cut settings
  logic                wr_btn; // Write to misc control

  // One debounce filter per button
  for (genvar i = 0; i < 3; i++) begin : g_btn
    pcb_debounce #(
      .CYC0 (DBNC_CYC0),
      .CYC1 (DBNC_CYC1),
      .CYC2 (DBNC_CYC2),
      .CYC3 (DBNC_CYC3)
    ) u_dbnc (
      .clk_sys_in (clk_sys_in),
      .resetn_in  (resetn_in),
      .pin_in     (power_button_in[i]),
      .sel_in     (s_q.btn.button_debounce_sel[i]),
      .level_out  (deb[i])
    );
  end

  assign wr_cut = reg_req_in.wr && (reg_req_in.addr == `PCB_ADDR_CUT);
  assign wr_btn = reg_req_in.wr && (reg_req_in.addr == `PCB_ADDR_BTN);

  // Register writes, reads, input filtering and request outputs
  always_comb begin
    s_d = s_q;
    // Synchronisers; a change counts once stages two and three agree
    s_d.srst_sync = {s_q.srst_sync[1:0], system_reset_n_in};
    s_d.wdi_sync  = {s_q.wdi_sync[1:0], watchdog_input_in};
    s_d.pri_sync  = {s_q.pri_sync[1:0], primary_lowpower_request_in};
    s_d.sec_sync  = {s_q.sec_sync[1:0], secondary_lowpower_request_in};
    if (s_q.srst_sync[1] == s_q.srst_sync[2]) begin
      s_d.srst_n = s_q.srst_sync[2];
    end
    if (s_q.wdi_sync[1] == s_q.wdi_sync[2]) begin
      s_d.watchdog_input = s_q.wdi_sync[2];
    end
    if (s_q.pri_sync[1] == s_q.pri_sync[2]) begin
      s_d.pri = s_q.pri_sync[2];
    end
    if (s_q.sec_sync[1] == s_q.sec_sync[2]) begin
      s_d.sec = s_q.sec_sync[2];
    end
    // Software writes, reserved bits masked off
    if (wr_cut) begin
      s_d.cut = pcb_pkg::pcb_cut_s'(reg_req_in.wdata & `PCB_CUT_WMASK);
    end
    if (wr_btn) begin
      s_d.btn = pcb_pkg::pcb_btn_s'(reg_req_in.wdata & `PCB_BTN_WMASK);
    end
    if (reg_req_in.wr && (reg_req_in.addr == `PCB_ADDR_MEM_A)) begin
      s_d.mem_a = reg_req_in.wdata & `PCB_MEM_WMASK;
    end
    if (reg_req_in.wr && (reg_req_in.addr == `PCB_ADDR_MEM_B)) begin
      s_d.mem_b = reg_req_in.wdata & `PCB_MEM_WMASK;
    end
    // Cut tally advances on top of any write, saturating
    if (cut_event_in && cut_tally_enable_in &&
        (s_d.cut.cut_event_tally != 4'hF)) begin
      s_d.cut.cut_event_tally = s_d.cut.cut_event_tally + 4'h1;
    end
    // System reset restores only its own fields to their reset values, and holds them
    if (!s_q.srst_n) begin
      s_d.btn.watchdog_reset_enable = `PCB_WDRST_RST;
      s_d.btn.lowpower_delay_ctrl   = `PCB_DLY_RST;
    end
    // Read answer one cycle after the strobe; unmapped reads zero
    s_d.rvalid = reg_req_in.rd;
    if (reg_req_in.rd) begin
      case (reg_req_in.addr)
        `PCB_ADDR_CUT:   s_d.rdata = s_q.cut;
        `PCB_ADDR_BTN:   s_d.rdata = s_q.btn;
        `PCB_ADDR_MEM_A: s_d.rdata = s_q.mem_a;
        `PCB_ADDR_MEM_B: s_d.rdata = s_q.mem_b;
        default:         s_d.rdata = 24'h000000;
      endcase
    end
    // Requests towards the power sequencer
    s_d.btn_req  = deb & s_q.btn.button_reset_enable;
    s_d.wdog_req = !s_q.watchdog_input && s_q.btn.watchdog_reset_enable;
    s_d.pri_req  = s_q.pri ^ s_q.btn.primary_lowpower_polarity;
    s_d.sec_req  = s_q.sec ^ s_q.btn.secondary_lowpower_polarity;
  end

  // State register, loaded with its reset values by the always-on power-on reset
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_q        <= '0;
      s_q.cut    <= `PCB_CUT_RST;
      s_q.btn    <= `PCB_BTN_RST;
      s_q.mem_a  <= `PCB_MEM_RST;
      s_q.mem_b  <= `PCB_MEM_RST;
      s_q.watchdog_input    <= 1'h1;
      s_q.wdi_sync <= 3'h7;                                 // Idle high pin
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_out              = s_q.rdata;
  assign reg_rvalid_out             = s_q.rvalid;
  assign cut_settings_out           = s_q.cut;
  assign btn_settings_out           = s_q.btn;
  assign button_reset_req_out       = s_q.btn_req;
  assign watchdog_reset_req_out     = s_q.wdog_req;
  assign primary_lowpower_req_out   = s_q.pri_req;
  assign secondary_lowpower_req_out = s_q.sec_req;

  property p_cut_write;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      wr_cut |=> (s_q.cut.cut_timer_value == $past(reg_req_in.wdata[7:0]))
             && (s_q.cut.cut_tally_limit == $past(reg_req_in.wdata[15:12]));
  endproperty
  a_cut_write: assert property (p_cut_write)
    else $error("Cut settings did not take the written value");

  property p_restart_write;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      wr_btn |=> (s_q.btn.auto_restart_enable == $past(reg_req_in.wdata[0]));
  endproperty
  a_restart_write: assert property (p_restart_write)
    else $error("Restart enable did not take the written value");

  property p_btn_req;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      (s_q.btn.button_reset_enable == 3'h0) |=>
        (button_reset_req_out == 3'h0);
  endproperty
  a_btn_req: assert property (p_btn_req)
    else $error("Button reset request not gated by its enable");

  property p_pri_pol;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      ##1 (primary_lowpower_req_out ==
           ($past(s_q.pri) ^ $past(s_q.btn.primary_lowpower_polarity)));
  endproperty
  a_pri_pol: assert property (p_pri_pol)
    else $error("Primary request polarity wrong");

  property p_sec_pol;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      $rose(s_q.sec) && !s_q.btn.secondary_lowpower_polarity
        && $stable(s_q.btn.secondary_lowpower_polarity)
        |=> secondary_lowpower_req_out;
  endproperty
  a_sec_pol: assert property (p_sec_pol)
    else $error("Secondary request not active high when polarity clear");

  property p_wd_srst;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      !s_q.srst_n |=> !btn_settings_out[`PCB_WDRST_BIT]
                      ##1 !watchdog_reset_req_out;
  endproperty
  a_wd_srst: assert property (p_wd_srst)
    else $error("Watchdog enable survived system reset");

  property p_drv_write;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      wr_btn |=> (s_q.btn.slow_clock_drive_sel ==
                  $past(reg_req_in.wdata[18:17]))
             && (s_q.btn.rsvd_lo == 2'h0);
  endproperty
  a_drv_write: assert property (p_drv_write)
    else $error("Slow clock drive select wrong after write");

  property p_dly_srst;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      !s_q.srst_n |=> (btn_settings_out[`PCB_DLY_LSB +: 2] == `PCB_DLY_RST);
  endproperty
  a_dly_srst: assert property (p_dly_srst)
    else $error("Standby delay not restored by system reset");

  property p_tally_en;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      !cut_tally_enable_in && !wr_cut |=> $stable(s_q.cut.cut_event_tally);
  endproperty
  a_tally_en: assert property (p_tally_en)
    else $error("Cut tally moved while disabled");

endmodule // pcb_power_regs

/* File: hdl/pcb_regs.svh */
// Offsets, write masks, reset values and debounce timing for the power
// control and backup register bank. Definitions only; included by name.
`ifndef PCB_REGS_SVH
`define PCB_REGS_SVH

// Register word offsets on the serial control port
`define PCB_ADDR_CUT      6'h0E
`define PCB_ADDR_BTN      6'h0F
`define PCB_ADDR_SPARE_A  6'h10
`define PCB_ADDR_SPARE_B  6'h11
`define PCB_ADDR_MEM_A    6'h12
`define PCB_ADDR_MEM_B    6'h13

// Writable bits of each register; all other bits read zero
`define PCB_CUT_WMASK     24'h00FFFF
`define PCB_BTN_WMASK     24'hC67FFF
`define PCB_MEM_WMASK     24'hFFFFFF

// Field positions used by the checks
`define PCB_WDRST_BIT     12
`define PCB_DLY_LSB       22

// Reset values
`define PCB_CUT_RST       24'h000000
`define PCB_BTN_RST       24'h400000
`define PCB_MEM_RST       24'h000000
`define PCB_WDRST_RST     1'h0
`define PCB_DLY_RST       2'h1

// Debounce times per select code, in ns, and their cycle counts
`define PCB_CLK_NS        4
`define PCB_DBNC0_NS      1000
`define PCB_DBNC1_NS      4000
`define PCB_DBNC2_NS      16000
`define PCB_DBNC3_NS      64000
`define PCB_NS2CYC(t)     (((t) + `PCB_CLK_NS - 1) / `PCB_CLK_NS)
`define PCB_DBNC0_CYC     `PCB_NS2CYC(`PCB_DBNC0_NS)
`define PCB_DBNC1_CYC     `PCB_NS2CYC(`PCB_DBNC1_NS)
`define PCB_DBNC2_CYC     `PCB_NS2CYC(`PCB_DBNC2_NS)
`define PCB_DBNC3_CYC     `PCB_NS2CYC(`PCB_DBNC3_NS)

`endif

/* File: hdl/pcb_pkg.sv */
// Types of the power control and backup register bank.
// Assumes the offsets and reset values come from pcb_regs.svh.
package pcb_pkg;

  // Power cut settings word
  typedef struct packed {
    logic [7:0] unused;             // Reads zero
    logic [3:0] cut_tally_limit;    // Maximum cut count
    logic [3:0] cut_event_tally;    // Cut counter
    logic [7:0] cut_timer_value;    // Cut timer
  } pcb_cut_s;

  // Power button and miscellaneous control word
  typedef struct packed {
    logic [1:0] lowpower_delay_ctrl;         // Standby delay
    logic [2:0] rsvd_hi;                     // Reads zero
    logic [1:0] slow_clock_drive_sel;        // Slow clock drive
    logic [1:0] rsvd_lo;                     // Reads zero
    logic [1:0] serial_port_drive_sel;       // Serial port drive
    logic       watchdog_reset_enable;       // Watchdog reset enable
    logic       secondary_lowpower_polarity; // Secondary active low
    logic       primary_lowpower_polarity;   // Primary active low
    logic [2:0][1:0] button_debounce_sel;    // Index 0 is button 1
    logic [2:0] button_reset_enable;         // Index 0 is button 1
    logic       auto_restart_enable;         // Restart after reset
  } pcb_btn_s;

  // Register access port
  typedef struct packed {
    logic [5:0]  addr;   // Word offset
    logic        wr;     // Write strobe
    logic        rd;     // Read strobe
    logic [23:0] wdata;  // Write data
  } pcb_req_s;

  // State of the debounce filter
  typedef struct packed {
    logic [2:0]  sync;   // Three-stage pin synchroniser
    logic        level;  // Debounced level
    logic [15:0] cnt;    // Stable time counter
  } pcb_dbnc_s;

  // State of the register bank
  typedef struct packed {
    pcb_cut_s    cut;          // Power cut settings
    pcb_btn_s    btn;          // Button and misc control
    logic [23:0] mem_a;        // First backup word
    logic [23:0] mem_b;        // Second backup word
    logic [23:0] rdata;        // Read data
    logic        rvalid;       // Read answer
    logic [2:0]  srst_sync;    // System reset synchroniser
    logic [2:0]  wdi_sync;     // Watchdog synchroniser
    logic [2:0]  pri_sync;     // Primary request synchroniser
    logic [2:0]  sec_sync;     // Secondary request synchroniser
    logic        srst_n;       // Filtered system reset
    logic        watchdog_input;          // Filtered watchdog
    logic        pri;          // Filtered primary request
    logic        sec;          // Filtered secondary request
    logic [2:0]  btn_req;      // Button reset requests
    logic        wdog_req;     // Watchdog reset request
    logic        pri_req;      // Primary request, active high
    logic        sec_req;      // Secondary request, active high
  } pcb_state_s;

endpackage

/* File: hdl/pcb_debounce.sv */
// Debounce filter for one power button pin.
// Assumes the pin is asynchronous; select comes from the register bank.
`timescale 1ns/10ps
`include "pcb_regs.svh"

module pcb_debounce #(
  parameter int unsigned CYC0 = `PCB_DBNC0_CYC,  // Code 0, shortest
  parameter int unsigned CYC1 = `PCB_DBNC1_CYC,  // Code 1
  parameter int unsigned CYC2 = `PCB_DBNC2_CYC,  // Code 2
  parameter int unsigned CYC3 = `PCB_DBNC3_CYC   // Code 3, longest
) (
  input  wire logic       clk_sys_in,    // System clock
  input  wire logic       resetn_in,     // Always-on power-on reset
  input  wire logic       pin_in,        // Raw button pin, pressed high
  input  wire logic [1:0] sel_in,        // Debounce select
  output logic            level_out      // Debounced level
);

  pcb_pkg::pcb_dbnc_s s_q;               // Filter state
  pcb_pkg::pcb_dbnc_s s_d;               // Next filter state
  logic [15:0]        limit;             // Cycles for the selected code

  // Selected stable time
  always_comb begin
    case (sel_in)
      2'h0:    limit = 16'(CYC0);
      2'h1:    limit = 16'(CYC1);
      2'h2:    limit = 16'(CYC2);
      default: limit = 16'(CYC3);
    endcase
  end

  // Level changes only after the new value held for the full time
  always_comb begin
    s_d      = s_q;
    s_d.sync = {s_q.sync[1:0], pin_in};
    if ((s_q.sync[1] != s_q.sync[2]) || (s_q.sync[2] == s_q.level)) begin
      s_d.cnt = 16'h0000;
    end else if (s_q.cnt + 16'h0001 >= limit) begin
      s_d.level = s_q.sync[2];
      s_d.cnt   = 16'h0000;
    end else begin
      s_d.cnt = s_q.cnt + 16'h0001;
    end
  end

  // State register
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level_out = s_q.level;

  property p_dbnc_hold;
    @(posedge clk_sys_in) disable iff (!resetn_in)
      (s_q.level != s_d.level) |-> (s_q.cnt + 16'h0001 >= limit);
  endproperty
  a_dbnc_hold: assert property (p_dbnc_hold)
    else $error("Debounced level changed before its time");

endmodule // pcb_debounce

/* File: dv/pcb_host_model.sv */
// Host model that issues word reads and writes on the register port.
// Assumes one clock; requests change just after a rising edge.
`timescale 1ns/10ps
module pcb_host_model (
  input  wire logic         clk_sys_in, // System clock
  input  wire logic [23:0]  rdata_in,   // Read data
  input  wire logic         rvalid_in,  // Read answer
  output pcb_pkg::pcb_req_s req_out     // Request to the bank
);
  // Idle with both strobes low from time zero
  initial begin
    req_out = '{addr: 6'h3F, wr: 1'b0, rd: 1'b0, wdata: 24'h000000};
  end
  // One write; data is inverted afterwards so stale data never lingers
  task automatic write(input logic [5:0] a, input logic [23:0] d);
    @(posedge clk_sys_in);
    req_out.addr  <= a;
    req_out.wdata <= d;
    req_out.wr    <= 1'b1;
    @(posedge clk_sys_in);
    req_out.wr    <= 1'b0;
    req_out.wdata <= ~d;
  endtask
  // One read; the answer is awaited for a few cycles only
  task automatic read(input logic [5:0] a, output logic [23:0] d,
                      output logic ok);
    int n;
    ok = 1'b0;
    d  = 'x;
    @(posedge clk_sys_in);
    req_out.addr <= a;
    req_out.rd   <= 1'b1;
    @(posedge clk_sys_in);
    req_out.rd   <= 1'b0;
    for (n = 0; n < 4 && !ok; n++) begin
      @(posedge clk_sys_in);
      if (rvalid_in === 1'b1) begin
        d  = rdata_in;
        ok = 1'b1;
      end
    end
  endtask
endmodule // pcb_host_model

/* File: dv/power_control_backup_regs_tb.sv */
// Self-checking bench for the power control and backup register bank.
// Assumes short debounce counts and the host model on the register port.
`timescale 1ns/10ps
module power_control_backup_regs_tb;
  logic              clk_sys_in;  // 250 MHz clock
  logic              resetn_in;   // Power-on reset
  logic              sys_rst_n;   // System reset pin
  logic              tally_en;    // Tally enable
  logic              cut_ev;      // Cut event pulse
  logic [2:0]        btn;         // Button pins
  logic              watchdog_input;         // Watchdog pin
  logic              pri;         // Primary request pin
  logic              sec;         // Secondary request pin
  pcb_pkg::pcb_req_s req;         // Register request
  logic [23:0]       rdata;       // Read data
  logic              rvalid;      // Read answer
  pcb_pkg::pcb_cut_s cut_o;       // Cut settings
  pcb_pkg::pcb_btn_s btn_o;       // Misc settings
  logic [2:0]        btn_req;     // Button reset requests
  logic              wd_req;      // Watchdog request
  logic              pri_req;     // Primary request out
  logic              sec_req;     // Secondary request out
  int                n_mismatch;  // Failed comparisons
  int                n_checks;    // All comparisons
  // Clock, 4 ns period
  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  pcb_power_regs #(.DBNC_CYC0(2), .DBNC_CYC1(3), .DBNC_CYC2(4),
                   .DBNC_CYC3(5)) u_dut (
    .clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .system_reset_n_in(sys_rst_n), .reg_req_in(req),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .cut_tally_enable_in(tally_en), .cut_event_in(cut_ev),
    .power_button_in(btn), .watchdog_input_in(watchdog_input),
    .primary_lowpower_request_in(pri),
    .secondary_lowpower_request_in(sec),
    .cut_settings_out(cut_o), .btn_settings_out(btn_o),
    .button_reset_req_out(btn_req), .watchdog_reset_req_out(wd_req),
    .primary_lowpower_req_out(pri_req),
    .secondary_lowpower_req_out(sec_req));
  pcb_host_model u_host (.clk_sys_in(clk_sys_in), .rdata_in(rdata),
                         .rvalid_in(rvalid), .req_out(req));
  // Verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Compare one value
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Read one word and compare; a missing answer ends the run
  task automatic rd_chk(input logic [5:0] a, input logic [23:0] exp);
    logic [23:0] d;
    logic        ok;
    u_host.read(a, d, ok);
    if (!ok) begin
      n_mismatch++;
      tally_and_finish();
    end else begin
      chk(d, exp);
    end
  endtask
  // Power-on reset values, spare words and an unmapped place
  task automatic t_reset_values();
    logic [5:0]  a[7] = '{6'h0E, 6'h0F, 6'h10, 6'h11, 6'h12, 6'h13, 6'h20};
    logic [23:0] e[7] = '{24'h000000, 24'h400000, 24'h000000, 24'h000000,
                          24'h000000, 24'h000000, 24'h000000};
    for (int i = 0; i < 7; i++) rd_chk(a[i], e[i]);
    chk(btn_o, 24'h400000);
    $display("reset values done");
  endtask
  // All-ones written everywhere; only writable bits stick
  task automatic t_masks();
    logic [5:0]  a[7] = '{6'h0E, 6'h0F, 6'h10, 6'h11, 6'h12, 6'h13, 6'h20};
    logic [23:0] e[7] = '{24'h00FFFF, 24'hC67FFF, 24'h000000, 24'h000000,
                          24'hFFFFFF, 24'hFFFFFF, 24'h000000};
    for (int i = 0; i < 7; i++) u_host.write(a[i], 24'hFFFFFF);
    for (int i = 0; i < 7; i++) rd_chk(a[i], e[i]);
    chk(cut_o, 24'h00FFFF);
    chk(btn_o, 24'hC67FFF);
    $display("write masks done");
  endtask
  // Pulse the cut event n times back to back
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk_sys_in);
      cut_ev <= 1'b1;
    end
    @(posedge clk_sys_in);
    cut_ev <= 1'b0;
  endtask
  // Tally counts only while enabled and stops at its top
  task automatic t_tally();
    u_host.write(6'h0E, 24'h00A05A);
    tally_en <= 1'b1;
    pulse(3);
    rd_chk(6'h0E, 24'h00A35A);
    tally_en <= 1'b0;
    pulse(2);
    rd_chk(6'h0E, 24'h00A35A);
    u_host.write(6'h0E, 24'h000E00);
    tally_en <= 1'b1;
    pulse(3);
    rd_chk(6'h0E, 24'h000F00);
    tally_en <= 1'b0;
    $display("cut tally done");
  endtask
  // Request polarity both ways for both inputs
  task automatic t_polarity();
    pri <= 1'b1;
    sec <= 1'b0;
    u_host.write(6'h0F, 24'h400000);
    repeat (8) @(posedge clk_sys_in);
    chk(24'({pri_req, sec_req}), 24'h000002);
    u_host.write(6'h0F, 24'h400C00);
    repeat (8) @(posedge clk_sys_in);
    chk(24'({pri_req, sec_req}), 24'h000001);
    pri <= 1'b0;
    sec <= 1'b1;
    repeat (8) @(posedge clk_sys_in);
    chk(24'({pri_req, sec_req}), 24'h000002);
    $display("polarity done");
  endtask
  // Watchdog reset only while enabled
  task automatic t_watchdog();
    u_host.write(6'h0F, 24'h400000);
    watchdog_input <= 1'b0;
    repeat (8) @(posedge clk_sys_in);
    chk(24'(wd_req), 24'h000000);
    u_host.write(6'h0F, 24'h401000);
    repeat (8) @(posedge clk_sys_in);
    chk(24'(wd_req), 24'h000001);
    watchdog_input <= 1'b1;
    repeat (8) @(posedge clk_sys_in);
    chk(24'(wd_req), 24'h000000);
    $display("watchdog done");
  endtask
  // Cycles from press to request for button i, debounce code s
  task automatic press(input int i, input int s, input logic en,
                       output int t);
    u_host.write(6'h0F, 24'h400000 | (24'(en) << (i + 1)) |
                        (24'(s) << (4 + 2 * i)));
    @(posedge clk_sys_in);
    btn[i] <= 1'b1;
    for (t = 0; t < 40 && btn_req[i] !== 1'b1; t++) @(posedge clk_sys_in);
    btn[i] <= 1'b0;
    repeat (30) @(posedge clk_sys_in);
  endtask
  // Each button: disabled gives nothing; code zero is the quickest
  task automatic t_buttons();
    int t0;
    int t1;
    int t2;
    int t3;
    for (int i = 0; i < 3; i++) begin
      press(i, 0, 1'b0, t0);
      chk(24'(t0), 24'h000028);
      press(i, 0, 1'b1, t0);
      press(i, 1, 1'b1, t1);
      press(i, 2, 1'b1, t2);
      press(i, 3, 1'b1, t3);
      chk(24'(t0 < t3 && t3 < 40), 24'h000001);
      chk(24'(t0 < t1 && t1 < t2 && t2 < t3), 24'h000001);
    end
    $display("buttons done");
  endtask
  // System reset clears the watchdog enable, sets delay to one
  task automatic t_sys_reset();
    u_host.write(6'h0F, 24'hC67FFF);
    sys_rst_n <= 1'b0;
    repeat (8) @(posedge clk_sys_in);
    rd_chk(6'h0F, 24'h466FFF);
    u_host.write(6'h0F, 24'hC67FFF);
    rd_chk(6'h0F, 24'h466FFF);
    rd_chk(6'h0E, 24'h000F00);
    rd_chk(6'h12, 24'hFFFFFF);
    sys_rst_n <= 1'b1;
    repeat (8) @(posedge clk_sys_in);
    $display("system reset done");
  endtask
  // Power-on reset held for ten cycles
  task automatic por();
    @(posedge clk_sys_in);
    resetn_in <= 1'b0;
    repeat (10) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
  endtask
  // Main sequence
  initial begin
    n_mismatch = 0;
    n_checks   = 0;
    resetn_in  = 1'b0;
    sys_rst_n  = 1'b1;
    tally_en   = 1'b0;
    cut_ev     = 1'b0;
    btn        = 3'h0;
    watchdog_input        = 1'b1;
    pri        = 1'b0;
    sec        = 1'b0;
    por();
    t_reset_values();
    t_masks();
    t_tally();
    t_polarity();
    t_watchdog();
    t_buttons();
    t_sys_reset();
    por();
    t_reset_values();
    tally_and_finish();
  end
endmodule // power_control_backup_regs_tb
